/* File: hw/gpio_function_mux.v */
// General-purpose pin function mux: input functions and output sources
//
// Behaviour
// - Four input registers, function in bits 4:1
// - Code 0001 forces first PLL holdover
// - Codes 0010/0011 give manual reference bits 1/0
// - Code 0100 sleep, 0101 output mute
// - Code 0110 oscillator type, 0111 high performance
// - Codes 1000-1010 pulse, reseed, restart requests
// - Code 1011 fanout mode, 1101 phase slip
// - Bit 0 enables the selected input function
// - Pin may be input and output together
// - Four output registers, source in bits 7:2
// - Codes 0/1 alarm and serial read data
// - Codes 2-5 loss flags inputs 3..0
// - Codes 6-9 first PLL status signals
// - Code 10 PLL2 lock, 13 both locked
// - Codes 11,12,14 sync, phase, sync request
// - Codes 15,16,20 active input status
// - Codes 17-19 converter and oscillator status
// - Codes 21-23 first PLL state bits
// - Codes 31/32 constant one and zero
// - Bit 1 push-pull else open-drain; bit 0 enables
`timescale 1ns/10ps
module gpio_function_mux
#(
  parameter NUM_PINS = 4
)
(
  // Clock and reset
  input wire ref_clk_i,
  input wire srst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  output reg [7:0] reg_rdata_o,
  // Pins
  input wire [NUM_PINS-1:0] general_input_pin_i,
  output reg [NUM_PINS-1:0] general_output_pin_o,
  output reg [NUM_PINS-1:0] general_output_pin_oe_o,
  // Internal status sources
  input wire alarm_i,
  input wire serial_read_data_i,
  input wire [3:0] loss_of_signal_flag_i,
  input wire pll1_holdover_i,
  input wire pll1_lock_i,
  input wire pll1_acquiring_i,
  input wire pll1_near_lock_i,
  input wire pll2_lock_i,
  input wire sysref_unsynced_i,
  input wire phase_status_i,
  input wire sync_req_status_i,
  input wire [1:0] pll1_active_input_i,
  input wire adc_range_status_i,
  input wire adc_status_i,
  input wire ref_osc_status_i,
  input wire active_input_status_i,
  input wire [2:0] pll1_fsm_state_i,
  // Internal requests
  output reg holdover_force_o,
  output reg [1:0] manual_ref_sel_o,
  output reg sleep_req_o,
  output reg mute_req_o,
  output reg vco_type_sel_o,
  output reg high_perf_o,
  output reg pulse_req_o,
  output reg reseed_req_o,
  output reg restart_req_o,
  output reg fanout_force_o,
  output reg slip_req_o
);
`include "gpio_mux_consts.vh"

  // Control registers per pin
  reg [7:0] in_ctrl_q [0:NUM_PINS-1];
  reg [7:0] out_ctrl_q [0:NUM_PINS-1];
  // Per-pin selected output level
  wire [NUM_PINS-1:0] src_level;
  // Per-pin enabled input level, one row per function
  wire [NUM_PINS-1:0] act_hold;
  wire [NUM_PINS-1:0] act_ref1;
  wire [NUM_PINS-1:0] act_ref0;
  wire [NUM_PINS-1:0] act_sleep;
  wire [NUM_PINS-1:0] act_mute;
  wire [NUM_PINS-1:0] act_vco;
  wire [NUM_PINS-1:0] act_perf;
  wire [NUM_PINS-1:0] act_pulse;
  wire [NUM_PINS-1:0] act_reseed;
  wire [NUM_PINS-1:0] act_restart;
  wire [NUM_PINS-1:0] act_fanout;
  wire [NUM_PINS-1:0] act_slip;
  // Read data next value
  reg [7:0] rdata_d;
  // Read decode loop index
  integer k;

  // Pin index of the per-pin logic
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : pin
      // Byte addresses of this pin's two registers
      localparam [31:0] IN_ADDR = `IN_CTRL_BASE + g;
      localparam [31:0] OUT_ADDR = `OUT_CTRL_BASE + g;
      // Decoded request levels of this pin alone
      reg hold_lvl;
      reg ref1_lvl;
      reg ref0_lvl;
      reg sleep_lvl;
      reg mute_lvl;
      reg vco_lvl;
      reg perf_lvl;
      reg pulse_lvl;
      reg reseed_lvl;
      reg restart_lvl;
      reg fanout_lvl;
      reg slip_lvl;

      // Register writes at own offset
      always @(posedge ref_clk_i)
      begin
        if (srst_i)
        begin
          // No reset value is given, so all fields start clear
          in_ctrl_q[g] <= `CTRL_RESET;
          out_ctrl_q[g] <= `CTRL_RESET;
        end
        else if (reg_wr_i)
        begin
          // Writes to other offsets leave both registers alone
          // Input register of this pin
          if (reg_addr_i == IN_ADDR[7:0])
            in_ctrl_q[g] <= reg_wdata_i;
          // Output register of this pin
          if (reg_addr_i == OUT_ADDR[7:0])
            out_ctrl_q[g] <= reg_wdata_i;
        end
      end

      // Output source select, independent of input use
      output_source_sel u_sel
      (
        .sel_i(out_ctrl_q[g][`OUT_SEL_MSB:`OUT_SEL_LSB]),
        .alarm_i(alarm_i),
        .serial_read_data_i(serial_read_data_i),
        .loss_of_signal_flag_i(loss_of_signal_flag_i),
        .pll1_holdover_i(pll1_holdover_i),
        .pll1_lock_i(pll1_lock_i),
        .pll1_acquiring_i(pll1_acquiring_i),
        .pll1_near_lock_i(pll1_near_lock_i),
        .pll2_lock_i(pll2_lock_i),
        .sysref_unsynced_i(sysref_unsynced_i),
        .phase_status_i(phase_status_i),
        .sync_req_status_i(sync_req_status_i),
        .pll1_active_input_i(pll1_active_input_i),
        .adc_range_status_i(adc_range_status_i),
        .adc_status_i(adc_status_i),
        .ref_osc_status_i(ref_osc_status_i),
        .active_input_status_i(active_input_status_i),
        .pll1_fsm_state_i(pll1_fsm_state_i),
        .level_o(src_level[g])
      );

      // Pin driver: push-pull drives both levels, open-drain only low
      always @(posedge ref_clk_i)
      begin
        if (srst_i)
        begin
          // Pad released while in reset
          general_output_pin_o[g] <= 1'b0;
          general_output_pin_oe_o[g] <= 1'b0;
        end
        else if (!out_ctrl_q[g][`OUT_EN_BIT])
        begin
          // Driver disabled
          general_output_pin_o[g] <= 1'b0;
          general_output_pin_oe_o[g] <= 1'b0;
        end
        else if (out_ctrl_q[g][`OUT_MODE_BIT])
        begin
          // Push-pull
          general_output_pin_o[g] <= src_level[g];
          general_output_pin_oe_o[g] <= 1'b1;
        end
        else
        begin
          // Open-drain
          general_output_pin_o[g] <= 1'b0;
          general_output_pin_oe_o[g] <= ~src_level[g];
        end
      end

      // Input function decode; disabled or reserved gives nothing
      // Software gates the pin before a code change, else a request may glitch
      always @*
      begin
        hold_lvl = 1'b0;
        ref1_lvl = 1'b0;
        ref0_lvl = 1'b0;
        sleep_lvl = 1'b0;
        mute_lvl = 1'b0;
        vco_lvl = 1'b0;
        perf_lvl = 1'b0;
        pulse_lvl = 1'b0;
        reseed_lvl = 1'b0;
        restart_lvl = 1'b0;
        fanout_lvl = 1'b0;
        slip_lvl = 1'b0;
        if (in_ctrl_q[g][`IN_EN_BIT])
        begin
          // Pin level passes through only while enabled
          case (in_ctrl_q[g][`IN_SEL_MSB:`IN_SEL_LSB])
            `FN_HOLDOVER: hold_lvl = general_input_pin_i[g];
            `FN_REFSEL1: ref1_lvl = general_input_pin_i[g];
            `FN_REFSEL0: ref0_lvl = general_input_pin_i[g];
            `FN_SLEEP: sleep_lvl = general_input_pin_i[g];
            `FN_MUTE: mute_lvl = general_input_pin_i[g];
            `FN_VCO_TYPE: vco_lvl = general_input_pin_i[g];
            `FN_HIPERF: perf_lvl = general_input_pin_i[g];
            `FN_PULSE: pulse_lvl = general_input_pin_i[g];
            `FN_RESEED: reseed_lvl = general_input_pin_i[g];
            `FN_RESTART: restart_lvl = general_input_pin_i[g];
            `FN_FANOUT: fanout_lvl = general_input_pin_i[g];
            `FN_SLIP: slip_lvl = general_input_pin_i[g];
            default: hold_lvl = 1'b0;
          endcase
        end
      end

      // Hand this pin's levels to the per-function rows
      assign act_hold[g] = hold_lvl;
      assign act_ref1[g] = ref1_lvl;
      assign act_ref0[g] = ref0_lvl;
      assign act_sleep[g] = sleep_lvl;
      assign act_mute[g] = mute_lvl;
      assign act_vco[g] = vco_lvl;
      assign act_perf[g] = perf_lvl;
      assign act_pulse[g] = pulse_lvl;
      assign act_reseed[g] = reseed_lvl;
      assign act_restart[g] = restart_lvl;
      assign act_fanout[g] = fanout_lvl;
      assign act_slip[g] = slip_lvl;
    end
  endgenerate

  // Requests: OR of all pins that carry each function
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      // Idle requests while in reset
      holdover_force_o <= 1'b0;
      manual_ref_sel_o <= 2'h0;
      sleep_req_o <= 1'b0;
      mute_req_o <= 1'b0;
      vco_type_sel_o <= 1'b0;
      high_perf_o <= 1'b0;
      pulse_req_o <= 1'b0;
      reseed_req_o <= 1'b0;
      restart_req_o <= 1'b0;
      fanout_force_o <= 1'b0;
      slip_req_o <= 1'b0;
    end
    else
    begin
      // Each request is the OR over the pins that carry it
      holdover_force_o <= |act_hold;
      manual_ref_sel_o <= {|act_ref1, |act_ref0};
      sleep_req_o <= |act_sleep;
      mute_req_o <= |act_mute;
      vco_type_sel_o <= |act_vco;
      high_perf_o <= |act_perf;
      pulse_req_o <= |act_pulse;
      reseed_req_o <= |act_reseed;
      restart_req_o <= |act_restart;
      fanout_force_o <= |act_fanout;
      slip_req_o <= |act_slip;
    end
  end

  // Read decode; unmapped offsets read zero
  always @*
  begin
    rdata_d = `RDATA_IDLE;
    // The two offset ranges do not overlap for up to 10 pins, so at most one match
    for (k = 0; k < NUM_PINS; k = k + 1)
    begin
      if (reg_addr_i == `IN_CTRL_BASE + k[7:0])
        rdata_d = in_ctrl_q[k];
      if (reg_addr_i == `OUT_CTRL_BASE + k[7:0])
        rdata_d = out_ctrl_q[k];
    end
  end

  // Registered read data
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= `RDATA_IDLE;
    else
      // Read data trails the address by one cycle
      reg_rdata_o <= rdata_d;
  end

endmodule

/* File: hw/gpio_mux_consts.vh */
// Register offsets, field positions and selection codes of the pin function mux
`ifndef GPIO_MUX_CONSTS_VH
`define GPIO_MUX_CONSTS_VH

// Register offsets
`define IN_CTRL_BASE 8'h46
`define OUT_CTRL_BASE 8'h50
`define CTRL_RESET 8'h00
`define RDATA_IDLE 8'h00

// Input control fields
`define IN_EN_BIT 0
`define IN_SEL_LSB 1
`define IN_SEL_MSB 4

// Output control fields
`define OUT_EN_BIT 0
`define OUT_MODE_BIT 1
`define OUT_SEL_LSB 2
`define OUT_SEL_MSB 7

// Input function codes
`define FN_HOLDOVER 4'h1
`define FN_REFSEL1 4'h2
`define FN_REFSEL0 4'h3
`define FN_SLEEP 4'h4
`define FN_MUTE 4'h5
`define FN_VCO_TYPE 4'h6
`define FN_HIPERF 4'h7
`define FN_PULSE 4'h8
`define FN_RESEED 4'h9
`define FN_RESTART 4'hA
`define FN_FANOUT 4'hB
`define FN_SLIP 4'hD

// Output source codes
`define SRC_ALARM 6'h00
`define SRC_SERIAL_RD 6'h01
`define SRC_LOSS3 6'h02
`define SRC_LOSS2 6'h03
`define SRC_LOSS1 6'h04
`define SRC_LOSS0 6'h05
`define SRC_P1_HOLD 6'h06
`define SRC_P1_LOCK 6'h07
`define SRC_P1_ACQ 6'h08
`define SRC_P1_NEAR 6'h09
`define SRC_P2_LOCK 6'h0A
`define SRC_NOSYNC 6'h0B
`define SRC_PHASE 6'h0C
`define SRC_BOTH_LOCK 6'h0D
`define SRC_SYNC_REQ 6'h0E
`define SRC_ACT_IN0 6'h0F
`define SRC_ACT_IN1 6'h10
`define SRC_ADC_RANGE 6'h11
`define SRC_ADC_STAT 6'h12
`define SRC_XO_STAT 6'h13
`define SRC_ACT_STAT 6'h14
`define SRC_FSM0 6'h15
`define SRC_FSM1 6'h16
`define SRC_FSM2 6'h17
`define SRC_ONE 6'h1F
`define SRC_ZERO 6'h20

`endif

/* File: hw/output_source_sel.v */
// Selects one internal status signal for one output pin
`timescale 1ns/10ps
module output_source_sel
(
  // Selection
  input wire [5:0] sel_i,
  // Internal status sources
  input wire alarm_i,
  input wire serial_read_data_i,
  input wire [3:0] loss_of_signal_flag_i,
  input wire pll1_holdover_i,
  input wire pll1_lock_i,
  input wire pll1_acquiring_i,
  input wire pll1_near_lock_i,
  input wire pll2_lock_i,
  input wire sysref_unsynced_i,
  input wire phase_status_i,
  input wire sync_req_status_i,
  input wire [1:0] pll1_active_input_i,
  input wire adc_range_status_i,
  input wire adc_status_i,
  input wire ref_osc_status_i,
  input wire active_input_status_i,
  input wire [2:0] pll1_fsm_state_i,
  // Selected level
  output reg level_o
);
`include "gpio_mux_consts.vh"

  // Source decode; unlisted codes give low
  always @*
  begin
    case (sel_i)
      `SRC_ALARM: level_o = alarm_i;
      `SRC_SERIAL_RD: level_o = serial_read_data_i;
      `SRC_LOSS3: level_o = loss_of_signal_flag_i[3];
      `SRC_LOSS2: level_o = loss_of_signal_flag_i[2];
      `SRC_LOSS1: level_o = loss_of_signal_flag_i[1];
      `SRC_LOSS0: level_o = loss_of_signal_flag_i[0];
      `SRC_P1_HOLD: level_o = pll1_holdover_i;
      `SRC_P1_LOCK: level_o = pll1_lock_i;
      `SRC_P1_ACQ: level_o = pll1_acquiring_i;
      `SRC_P1_NEAR: level_o = pll1_near_lock_i;
      `SRC_P2_LOCK: level_o = pll2_lock_i;
      `SRC_BOTH_LOCK: level_o = pll1_lock_i & pll2_lock_i;
      `SRC_NOSYNC: level_o = sysref_unsynced_i;
      `SRC_PHASE: level_o = phase_status_i;
      `SRC_SYNC_REQ: level_o = sync_req_status_i;
      `SRC_ACT_IN0: level_o = pll1_active_input_i[0];
      `SRC_ACT_IN1: level_o = pll1_active_input_i[1];
      `SRC_ACT_STAT: level_o = active_input_status_i;
      `SRC_ADC_RANGE: level_o = adc_range_status_i;
      `SRC_ADC_STAT: level_o = adc_status_i;
      `SRC_XO_STAT: level_o = ref_osc_status_i;
      `SRC_FSM0: level_o = pll1_fsm_state_i[0];
      `SRC_FSM1: level_o = pll1_fsm_state_i[1];
      `SRC_FSM2: level_o = pll1_fsm_state_i[2];
      `SRC_ONE: level_o = 1'b1;
      `SRC_ZERO: level_o = 1'b0;
      default: level_o = 1'b0;
    endcase
  end

endmodule

/* File: tb/gpio_function_mux_properties.sv */
// Port checker of the pin function mux, bound into the top module
`timescale 1ns/10ps
module gpio_function_mux_properties
#(
  parameter NUM_PINS = 4
)
(
  // Clock and reset
  input wire ref_clk_i,
  input wire srst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire [7:0] reg_rdata_o,
  // Pins
  input wire [NUM_PINS-1:0] general_input_pin_i,
  input wire [NUM_PINS-1:0] general_output_pin_o,
  input wire [NUM_PINS-1:0] general_output_pin_oe_o,
  // Sources and requests
  input wire alarm_i,
  input wire pll1_lock_i,
  input wire pll2_lock_i,
  input wire holdover_force_o,
  input wire slip_req_o,
  input wire sleep_req_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Shadow copies of the control registers
  reg [7:0] in_q [0:3];
  reg [7:0] out_q [0:3];
  // Address decode
  wire in_hit = reg_addr_i >= 8'h46 && reg_addr_i <= 8'h49;
  wire out_hit = reg_addr_i >= 8'h50 && reg_addr_i <= 8'h53;
  wire [1:0] in_idx = reg_addr_i[1:0] + 2'h2;
  // Expected request levels
  reg hold_e;
  reg slip_e;
  reg any_en;
  integer i;
  integer j;
  // Follow writes as the register file does
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        in_q[i] <= 8'h00;
        out_q[i] <= 8'h00;
      end
    end
    else if (reg_wr_i && in_hit)
      in_q[in_idx] <= reg_wdata_i;
    else if (reg_wr_i && out_hit)
      out_q[reg_addr_i[1:0]] <= reg_wdata_i;
  end
  // OR of enabled pins per function
  always @*
  begin
    hold_e = 1'b0;
    slip_e = 1'b0;
    any_en = 1'b0;
    for (j = 0; j < 4; j = j + 1)
    begin
      hold_e = hold_e | (in_q[j][4:0] == 5'h03 && general_input_pin_i[j]);
      slip_e = slip_e | (in_q[j][4:0] == 5'h1B && general_input_pin_i[j]);
      any_en = any_en | in_q[j][0];
    end
  end
  a_unmapped_zero: assert property (!(in_hit || out_hit) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_write_back: assert property (reg_wr_i && (in_hit || out_hit) ##1
    !reg_wr_i && $stable(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("readback differs from write");
  a_hold_route: assert property (1'b1 |=> holdover_force_o == $past(hold_e))
    else $error("holdover request wrong");
  a_slip_route: assert property (1'b1 |=> slip_req_o == $past(slip_e))
    else $error("slip request wrong");
  a_none_enabled: assert property (!any_en |=> !holdover_force_o && !slip_req_o &&
    !sleep_req_o)
    else $error("request while disabled");
  genvar p;
  // Per-pin driver checks
  for (p = 0; p < 4; p = p + 1)
  begin : g_pin
    a_drv_released: assert property (!out_q[p][0] |=> !general_output_pin_oe_o[p])
      else $error("disabled driver drives");
    a_od_low: assert property (out_q[p][1:0] == 2'b01 |=> !general_output_pin_o[p])
      else $error("open-drain drives high");
    a_const_one: assert property (out_q[p] == 8'h7F |=>
      general_output_pin_oe_o[p] && general_output_pin_o[p])
      else $error("constant one missing");
    a_const_zero: assert property (out_q[p] == 8'h83 |=>
      general_output_pin_oe_o[p] && !general_output_pin_o[p])
      else $error("constant zero missing");
    a_alarm_route: assert property (out_q[p] == 8'h03 |=>
      general_output_pin_o[p] == $past(alarm_i))
      else $error("alarm not routed");
    a_both_lock: assert property (out_q[p] == 8'h37 |=>
      general_output_pin_o[p] == $past(pll1_lock_i && pll2_lock_i))
      else $error("joint lock wrong");
  end
  c_const_out: cover property (out_q[0] == 8'h7F);
  c_holdover: cover property (holdover_force_o);
  c_out_write: cover property (reg_wr_i && out_hit);
endmodule

bind gpio_function_mux gpio_function_mux_properties #(.NUM_PINS(NUM_PINS)) u_props
(
  .ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o,
  .general_input_pin_i, .general_output_pin_o, .general_output_pin_oe_o,
  .alarm_i, .pll1_lock_i, .pll2_lock_i, .holdover_force_o, .slip_req_o, .sleep_req_o
);

/* File: tb/pin_side_model.sv */
// Far-side model: drives the input pins, resolves the output pads
`timescale 1ns/10ps
module pin_side_model
(
  // Levels asked for by the bench
  input wire [3:0] drive_lvl_i,
  // Device pin drivers
  input wire [3:0] general_output_pin_o,
  input wire [3:0] general_output_pin_oe_o,
  // Pin levels
  output wire [3:0] pin_lvl_o,
  output wire [3:0] pad_o
);
  // External logic sets the input pin level
  assign pin_lvl_o = drive_lvl_i;
  // Pull-up lifts a released or open-drain pad
  assign pad_o = (general_output_pin_oe_o & general_output_pin_o) | ~general_output_pin_oe_o;
endmodule

/* File: tb/gpio_function_mux_tb.sv */
// Self-checking bench of the pin function mux
`timescale 1ns/10ps
module gpio_function_mux_tb;
  // Clock, reset, register port
  reg ref_clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_wr_i = 1'b0;
  wire [7:0] reg_rdata_o;
  // Pins
  reg [3:0] drive_lvl = 4'h0;
  wire [3:0] general_input_pin_i, general_output_pin_o, general_output_pin_oe_o, pad;
  // Status sources, packed
  reg [22:0] st = 23'h000000;
  wire alarm_i, serial_read_data_i, pll1_holdover_i, pll1_lock_i, pll1_acquiring_i;
  wire pll1_near_lock_i, pll2_lock_i, sysref_unsynced_i, phase_status_i, sync_req_status_i;
  wire adc_range_status_i, adc_status_i, ref_osc_status_i, active_input_status_i;
  wire [3:0] loss_of_signal_flag_i;
  wire [1:0] pll1_active_input_i, manual_ref_sel_o;
  wire [2:0] pll1_fsm_state_i;
  // Requests
  wire holdover_force_o, sleep_req_o, mute_req_o, vco_type_sel_o, high_perf_o, pulse_req_o;
  wire reseed_req_o, restart_req_o, fanout_force_o, slip_req_o;
  wire [11:0] req = {holdover_force_o, manual_ref_sel_o, sleep_req_o, mute_req_o,
    vco_type_sel_o, high_perf_o, pulse_req_o, reseed_req_o, restart_req_o,
    fanout_force_o, slip_req_o};
  integer miscompares = 0;
  integer cmp_count = 0;
  integer c, p, k;
  assign {alarm_i, serial_read_data_i, loss_of_signal_flag_i, pll1_holdover_i, pll1_lock_i,
    pll1_acquiring_i, pll1_near_lock_i, pll2_lock_i, sysref_unsynced_i, phase_status_i,
    sync_req_status_i, pll1_active_input_i, adc_range_status_i, adc_status_i,
    ref_osc_status_i, active_input_status_i, pll1_fsm_state_i} = st;
  gpio_function_mux #(.NUM_PINS(4)) u_dut
  (
    .ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o,
    .general_input_pin_i, .general_output_pin_o, .general_output_pin_oe_o, .alarm_i,
    .serial_read_data_i, .loss_of_signal_flag_i, .pll1_holdover_i, .pll1_lock_i,
    .pll1_acquiring_i, .pll1_near_lock_i, .pll2_lock_i, .sysref_unsynced_i, .phase_status_i,
    .sync_req_status_i, .pll1_active_input_i, .adc_range_status_i, .adc_status_i,
    .ref_osc_status_i, .active_input_status_i, .pll1_fsm_state_i, .holdover_force_o,
    .manual_ref_sel_o, .sleep_req_o, .mute_req_o, .vco_type_sel_o, .high_perf_o,
    .pulse_req_o, .reseed_req_o, .restart_req_o, .fanout_force_o, .slip_req_o
  );
  pin_side_model u_pins
  (
    .drive_lvl_i(drive_lvl), .general_output_pin_o, .general_output_pin_oe_o,
    .pin_lvl_o(general_input_pin_i), .pad_o(pad)
  );
  // 250 MHz clock
  initial forever #2 ref_clk_i = ~ref_clk_i;
  // Compare and count
  task chk(input [11:0] got, input [11:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // One-cycle write strobe
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  end
  endtask
  // Read data one cycle after the address
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(negedge ref_clk_i);
    reg_addr_i = a;
    @(negedge ref_clk_i);
    chk(reg_rdata_o, e);
  end
  endtask
  task settle;
    repeat (2) @(negedge ref_clk_i);
  endtask
  // Request vector for a function code
  function [11:0] exp_req(input [3:0] f);
    if (f >= 4'h1 && f <= 4'hB)
      exp_req = 12'h800 >> (f - 4'h1);
    else
      exp_req = (f == 4'hD) ? 12'h001 : 12'h000;
  endfunction
  // Pin level for a source code
  function exp_src(input [5:0] s);
    if (s <= 6'h0C)
      exp_src = st[22 - s];
    else if (s == 6'h0D)
      exp_src = st[15] & st[12];
    else if (s == 6'h0E)
      exp_src = st[9];
    else if (s == 6'h0F || s == 6'h10)
      exp_src = st[s - 8];
    else if (s <= 6'h14)
      exp_src = st[23 - s];
    else if (s <= 6'h17)
      exp_src = st[s - 21];
    else
      exp_src = (s == 6'h1F);
  endfunction
  task end_sim;
  begin
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // Hang guard
  initial
  begin
    #40000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial
  begin
    repeat (10) @(negedge ref_clk_i);
    srst_i = 1'b0;
    // Reset values, unmapped place
    for (k = 0; k < 4; k = k + 1)
    begin
      rd(8'h46 + k[7:0], 8'h00);
      rd(8'h50 + k[7:0], 8'h00);
    end
    wr(8'h4A, 8'h1F);
    rd(8'h4A, 8'h00);
    // Every function code, gated then enabled
    for (c = 0; c < 16; c = c + 1)
    begin
      p = c % 4;
      wr(8'h46 + p[7:0], {3'h0, c[3:0], 1'b0});
      rd(8'h46 + p[7:0], {3'h0, c[3:0], 1'b0});
      drive_lvl = 4'h1 << p;
      settle;
      chk(req, 12'h000);
      wr(8'h46 + p[7:0], {3'h0, c[3:0], 1'b1});
      settle;
      chk(req, exp_req(c[3:0]));
      drive_lvl = ~(4'h1 << p);
      settle;
      chk(req, 12'h000);
      wr(8'h46 + p[7:0], 8'h00);
    end
    // Every source code, both status polarities
    for (k = 0; k < 2; k = k + 1)
    begin
      st = k ? 23'h49C36 : ~23'h49C36;
      for (c = 0; c < 34; c = c + 1)
      begin
        p = c % 4;
        wr(8'h50 + p[7:0], {c[5:0], 2'b11});
        settle;
        chk(general_output_pin_o[p], exp_src(c[5:0]));
        chk(pad[p], exp_src(c[5:0]));
      end
    end
    rd(8'h51, 8'h87);
    // Driver modes
    wr(8'h50, 8'h81);
    settle;
    chk({general_output_pin_oe_o[0], pad[0]}, 12'h002);
    wr(8'h50, 8'h7D);
    settle;
    chk({general_output_pin_oe_o[0], pad[0]}, 12'h001);
    wr(8'h50, 8'h7E);
    settle;
    chk(general_output_pin_oe_o[0], 12'h000);
    // One pin as input and output at once
    wr(8'h46, 8'h02);
    wr(8'h46, 8'h03);
    wr(8'h50, 8'h7F);
    drive_lvl = 4'h1;
    settle;
    chk({holdover_force_o, general_output_pin_oe_o[0], general_output_pin_o[0]}, 12'h007);
    // Mid-run reset clears the registers and releases the pad
    srst_i = 1'b1;
    settle;
    srst_i = 1'b0;
    rd(8'h50, 8'h00);
    chk({holdover_force_o, general_output_pin_oe_o[0]}, 12'h000);
    end_sim;
  end
endmodule
